// ===== inc/lfs_pkg.sv
/*
 lfs_pkg: constants, channel state enum and signal bundles of the
 LED channel fault supervisor.
 Assumes a 25 MHz local clock; all comparator levels arrive already clocked.
*/
// Function
// - hold all logic reset until supply rises
// - supply below falling threshold turns everything off
// - external fault bus low disables all channels
// - internal fault asserts fault bus pulldown
// - enable high drives channel, low stops diagnostics
// - each enable gates only its channel
// - short checks only while channel enabled
// - sustained low output raises short fault
// - both outputs high restart short deglitch
// - faulty channel off, retry current regardless
// - output high during retry clears fault
// - short deglitch about 125 us
// - recovery condition held about 125 us
// - fault bus sensing deglitched about 10 us
// - recovery delay about 50 us
package lfs_pkg;
    localparam int LFS_NCH = 4;
    localparam int LFS_CLK_MHZ = 25;
    localparam int LFS_SHORT_DEG_US = 125;
    localparam int LFS_RECOV_DEG_US = 125;
    localparam int LFS_BUS_DEG_US = 10;
    localparam int LFS_RECOV_DLY_US = 50;
    // whole microseconds at whole megahertz, so rounding never applies
    localparam int LFS_SHORT_DEG_CYC = LFS_SHORT_DEG_US * LFS_CLK_MHZ;
    localparam int LFS_RECOV_DEG_CYC = LFS_RECOV_DEG_US * LFS_CLK_MHZ;
    localparam int LFS_BUS_DEG_CYC = LFS_BUS_DEG_US * LFS_CLK_MHZ;
    localparam int LFS_RECOV_DLY_CYC = LFS_RECOV_DLY_US * LFS_CLK_MHZ;

    typedef enum logic [1:0] {CH_RUN, CH_SHORT, CH_RECOVER} lfs_ch_e;

    // below_*: under short_low_threshold, above_*: over short_release_threshold
    typedef struct packed {
        logic [LFS_NCH-1:0] below_direct;
        logic [LFS_NCH-1:0] below_shared;
        logic [LFS_NCH-1:0] above_direct;
        logic [LFS_NCH-1:0] above_shared;
    } lfs_cmp_s;

    typedef struct packed {
        logic [LFS_NCH-1:0] reg_on;
        logic [LFS_NCH-1:0] retry_on;
    } lfs_drive_s;
endpackage

// ===== core/lfs_timer.sv
/*
 lfs_timer: saturating interval counter with a run-time limit.
 Assumes the caller clears it on every phase change.
*/
`timescale 1ns/10ps
module lfs_timer import lfs_pkg::*; #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // control
    input wire logic clr,
    input wire logic run,
    input wire logic [W-1:0] lim,
    // status
    output logic done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (clr) begin
            cnt_next = '0;
        end else if (run && cnt_reg < lim) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // saturates at the limit so a held condition never wraps to a false restart
    assign done = (cnt_reg >= lim);
endmodule

// ===== core/lfs_top.sv
/*
 lfs_top: power-on gating, per-channel short-to-ground supervision with
 retry and recovery, and the shared open-drain fault bus.
 Assumes comparator and enable inputs synchronous to mclk; the bus wire is
 resolved outside from fault_bus_oe.
*/
`timescale 1ns/10ps
module lfs_top import lfs_pkg::*; #(
    parameter int SG_DEG_CYC = LFS_SHORT_DEG_CYC,
    parameter int RECOV_DEG_CYC = LFS_RECOV_DEG_CYC,
    parameter int BUS_DEG_CYC = LFS_BUS_DEG_CYC,
    parameter int RECOV_DLY_CYC = LFS_RECOV_DLY_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // supply comparators
    input wire logic supply_above_rise,
    input wire logic supply_below_fall,
    // channel control and sensing
    input wire logic [LFS_NCH-1:0] channel_enable_input,
    input wire lfs_cmp_s cmp,
    // fault bus
    input wire logic fault_bus_in,
    output logic fault_bus_out,
    output logic fault_bus_oe,
    // drivers and status
    output lfs_drive_s drive,
    output logic [LFS_NCH-1:0] short_fault,
    output logic low_current_mode
);
    localparam int TW = $clog2(SG_DEG_CYC + RECOV_DEG_CYC + RECOV_DLY_CYC + BUS_DEG_CYC + 1);
    localparam logic [TW-1:0] SG_LIM = TW'(SG_DEG_CYC);
    localparam logic [TW-1:0] RDEG_LIM = TW'(RECOV_DEG_CYC);
    localparam logic [TW-1:0] RDLY_LIM = TW'(RECOV_DLY_CYC);
    localparam logic [TW-1:0] BUS_LIM = TW'(BUS_DEG_CYC);

    function automatic logic [TW-1:0] phase_lim(input lfs_ch_e s);
        logic [TW-1:0] l;
        l = SG_LIM;
        if (s == CH_SHORT) begin
            l = RDEG_LIM;
        end else if (s == CH_RECOVER) begin
            l = RDLY_LIM;
        end
        return l;
    endfunction

    logic por_ok_reg;
    logic por_ok_next;
    logic bus_low_reg;
    logic bus_low_next;
    logic bus_clr;
    logic bus_done;
    logic bus_flip;
    logic ext_low;
    lfs_ch_e state_reg [LFS_NCH];
    lfs_ch_e st_next [LFS_NCH];
    logic [LFS_NCH-1:0] en_eff;
    logic [LFS_NCH-1:0] any_below;
    logic [LFS_NCH-1:0] all_above;
    logic [LFS_NCH-1:0] t_run;
    logic [LFS_NCH-1:0] t_clr;
    logic [LFS_NCH-1:0] t_done;
    logic [TW-1:0] t_lim [LFS_NCH];
    lfs_drive_s drive_reg;
    lfs_drive_s drive_next;
    logic [LFS_NCH-1:0] short_reg;
    logic [LFS_NCH-1:0] short_next;
    logic oe_reg;
    logic oe_next;
    logic low_reg;
    logic low_next;

    // power-on gate; falling threshold wins over rising
    always_comb begin
        por_ok_next = por_ok_reg;
        if (supply_below_fall) begin
            por_ok_next = 1'b0;
        end else if (supply_above_rise) begin
            por_ok_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            por_ok_reg <= 1'b0;
        end else begin
            por_ok_reg <= por_ok_next;
        end
    end

    // fault bus filter: level must differ for the whole interval to flip
    // while we pull, the line says nothing about others; restarting from high
    // keeps our own release from being read as a foreign low afterwards
    assign bus_flip = bus_done && ((!fault_bus_in) != bus_low_reg);
    assign bus_clr = !por_ok_reg || oe_reg || ((!fault_bus_in) == bus_low_reg) || bus_flip;

    lfs_timer #(.W(TW)) u_bus_t (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(bus_clr),
        .run(1'b1),
        .lim(BUS_LIM),
        .done(bus_done)
    );

    always_comb begin
        bus_low_next = bus_low_reg;
        if (!por_ok_reg) begin
            bus_low_next = 1'b0;
        end else if (oe_reg) begin
            bus_low_next = 1'b0;
        end else if (bus_flip) begin
            bus_low_next = !bus_low_reg;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_low_reg <= 1'b0;
        end else begin
            bus_low_reg <= bus_low_next;
        end
    end

    // our own pulldown also reads back low; only a foreign low counts
    assign ext_low = bus_low_reg && !oe_reg;

    // per-channel supervision
    always_comb begin
        for (int i = 0; i < LFS_NCH; i++) begin
            en_eff[i] = channel_enable_input[i] && por_ok_reg && !ext_low;
            any_below[i] = cmp.below_direct[i] || cmp.below_shared[i];
            all_above[i] = cmp.above_direct[i] && cmp.above_shared[i];
            st_next[i] = state_reg[i];
            t_run[i] = 1'b0;
            t_clr[i] = 1'b0;
            t_lim[i] = phase_lim(state_reg[i]);
            if (!por_ok_reg) begin
                st_next[i] = CH_RUN;
                t_clr[i] = 1'b1;
            end else begin
                unique case (state_reg[i])
                    CH_RUN: begin
                        if (!en_eff[i] || all_above[i]) begin
                            t_clr[i] = 1'b1;
                        end else if (t_done[i]) begin
                            st_next[i] = CH_SHORT;
                            t_clr[i] = 1'b1;
                        end else begin
                            t_run[i] = any_below[i];
                        end
                    end
                    CH_SHORT: begin
                        if (!all_above[i]) begin
                            t_clr[i] = 1'b1;
                        end else if (t_done[i]) begin
                            st_next[i] = CH_RECOVER;
                            t_clr[i] = 1'b1;
                        end else begin
                            t_run[i] = 1'b1;
                        end
                    end
                    CH_RECOVER: begin
                        if (t_done[i]) begin
                            st_next[i] = CH_RUN;
                            t_clr[i] = 1'b1;
                        end else begin
                            t_run[i] = 1'b1;
                        end
                    end
                    default: begin
                        st_next[i] = CH_RUN;
                        t_clr[i] = 1'b1;
                    end
                endcase
            end
        end
    end

    for (genvar g = 0; g < LFS_NCH; g++) begin : g_ch
        lfs_timer #(.W(TW)) u_ch_t (
            .mclk(mclk),
            .arst_n(arst_n),
            .clr(t_clr[g]),
            .run(t_run[g]),
            .lim(t_lim[g]),
            .done(t_done[g])
        );
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < LFS_NCH; i++) begin
                state_reg[i] <= CH_RUN;
            end
        end else begin
            for (int i = 0; i < LFS_NCH; i++) begin
                state_reg[i] <= st_next[i];
            end
        end
    end

    // output drivers and fault bus
    always_comb begin
        for (int i = 0; i < LFS_NCH; i++) begin
            drive_next.reg_on[i] = en_eff[i] && (state_reg[i] == CH_RUN);
            // retry ignores the enable so a short can be seen to clear
            drive_next.retry_on[i] = por_ok_reg && !ext_low
                && (state_reg[i] != CH_RUN);
            short_next[i] = por_ok_reg && (state_reg[i] != CH_RUN);
        end
        oe_next = |short_next;
        low_next = ext_low;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            drive_reg <= '0;
            short_reg <= '0;
            oe_reg <= 1'b0;
            low_reg <= 1'b0;
        end else begin
            drive_reg <= drive_next;
            short_reg <= short_next;
            oe_reg <= oe_next;
            low_reg <= low_next;
        end
    end

    assign drive = drive_reg;
    assign short_fault = short_reg;
    assign fault_bus_oe = oe_reg;
    assign fault_bus_out = 1'b0;
    assign low_current_mode = low_reg;

    // helper: consecutive low-output cycles on channel 0
    logic [TW-1:0] run_len_reg;
    logic [TW-1:0] run_len_next;
    always_comb begin
        run_len_next = run_len_reg;
        if (!en_eff[0] || all_above[0] || state_reg[0] != CH_RUN) begin
            run_len_next = '0;
        end else if (any_below[0] && run_len_reg < SG_LIM) begin
            run_len_next = run_len_reg + 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            run_len_reg <= '0;
        end else begin
            run_len_reg <= run_len_next;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    por_hold_a: assert property (!por_ok_reg |=> drive.reg_on == '0)
        else $error("channel on before power-on");
    supply_fall_a: assert property (supply_below_fall |=> ##1 drive == '0)
        else $error("output alive after supply fall");
    ext_fault_a: assert property (ext_low |=> drive == '0 && low_current_mode)
        else $error("outputs not off on external bus low");
    pulldown_a: assert property (state_reg[0] == CH_SHORT && por_ok_reg |=> fault_bus_oe)
        else $error("no pulldown during short fault");
    enable_off_a: assert property (!channel_enable_input[1] |=> !drive.reg_on[1])
        else $error("disabled channel still driven");
    diag_gate_a: assert property (state_reg[0] == CH_RUN && !en_eff[0]
        |=> state_reg[0] == CH_RUN)
        else $error("short raised on disabled channel");
    short_deg_a: assert property (state_reg[0] == CH_RUN && st_next[0] == CH_SHORT
        |-> run_len_reg >= SG_LIM)
        else $error("short raised before deglitch expired");
    retry_on_a: assert property (state_reg[0] == CH_SHORT && por_ok_reg && !ext_low
        |=> drive.retry_on[0] && !drive.reg_on[0])
        else $error("retry current wrong during short");
    recover_a: assert property (state_reg[0] == CH_SHORT && !all_above[0]
        |=> state_reg[0] != CH_RECOVER)
        else $error("recovery without output released");
    release_a: assert property (por_ok_reg && short_next == '0 |=> !fault_bus_oe)
        else $error("pulldown held with no fault");
    bus_deg_a: assert property ($rose(bus_low_reg) |-> !$past(fault_bus_in))
        else $error("bus filter flipped without low input");

    short_enter_c: cover property (state_reg[0] == CH_RUN ##1 state_reg[0] == CH_SHORT);
    recover_done_c: cover property (state_reg[0] == CH_RECOVER ##1 state_reg[0] == CH_RUN);
    ext_fault_c: cover property ($rose(low_current_mode));
    por_drop_c: cover property ($fell(por_ok_reg));
endmodule

// ===== bench/lfs_load_model.sv
/*
 lfs_load_model: four LED strings with short injection on either output path,
 and the shared fault bus with its pull-up and one foreign driver on it.
 Assumes drive and the pulldown pins come straight from lfs_top.
*/
`timescale 1ns/10ps
module lfs_load_model import lfs_pkg::*; (
    // from the supervisor
    input wire lfs_drive_s drive,
    input wire logic fault_bus_out,
    input wire logic fault_bus_oe,
    // fault injection
    input wire logic [LFS_NCH-1:0] short_direct,
    input wire logic [LFS_NCH-1:0] short_shared,
    input wire logic foreign_pull,
    // to the supervisor
    output lfs_cmp_s cmp,
    output logic fault_bus_in
);
    logic [LFS_NCH-1:0] powered;

    // an unpowered string sits at ground, so it reads low just like a short
    assign powered = drive.reg_on | drive.retry_on;
    assign cmp = {short_direct | ~powered, short_shared | ~powered,
                  ~short_direct & powered, ~short_shared & powered};
    // pull-up wins only while nobody pulls the wire down
    assign fault_bus_in = !((fault_bus_oe && !fault_bus_out) || foreign_pull);
endmodule

// ===== bench/tb_lfs_top.sv
/*
 tb_lfs_top: self-checking bench for the fault supervisor with short counts.
 Assumes lfs_load_model stands for the strings and the fault bus.
*/
`timescale 1ns/10ps
module tb_lfs_top import lfs_pkg::*; ;
    localparam int SG = 8;
    localparam int RD = 8;
    localparam int RY = 4;
    localparam int BD = 3;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic supply_above_rise = 1'b0;
    logic supply_below_fall = 1'b0;
    logic [LFS_NCH-1:0] channel_enable_input = 4'h0;
    logic [LFS_NCH-1:0] short_direct = 4'h0;
    logic [LFS_NCH-1:0] short_shared = 4'h0;
    logic foreign_pull = 1'b0;
    lfs_cmp_s cmp;
    lfs_drive_s drive;
    logic fault_bus_in;
    logic fault_bus_out;
    logic fault_bus_oe;
    logic low_current_mode;
    logic [LFS_NCH-1:0] short_fault;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    lfs_top #(.SG_DEG_CYC(SG), .RECOV_DEG_CYC(RD), .BUS_DEG_CYC(BD), .RECOV_DLY_CYC(RY)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .supply_above_rise(supply_above_rise),
        .supply_below_fall(supply_below_fall), .channel_enable_input(channel_enable_input),
        .cmp(cmp), .fault_bus_in(fault_bus_in), .fault_bus_out(fault_bus_out),
        .fault_bus_oe(fault_bus_oe), .drive(drive), .short_fault(short_fault),
        .low_current_mode(low_current_mode));
    lfs_load_model i_load (
        .drive(drive), .fault_bus_out(fault_bus_out), .fault_bus_oe(fault_bus_oe),
        .short_direct(short_direct), .short_shared(short_shared),
        .foreign_pull(foreign_pull), .cmp(cmp), .fault_bus_in(fault_bus_in));

    always #20 mclk = ~mclk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the whole run needs under two hundred cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // the flag must take its new value neither early nor late
    task automatic wait_for(input int ch, input logic v, input int lo, input int hi,
                            input string what);
        int n;
        n = 0;
        while (short_fault[ch] !== v && n <= hi) begin
            @(negedge mclk);
            n++;
        end
        chk(16'(n >= lo && n <= hi), 16'h1, what);
    endtask

    task automatic t_por();
        channel_enable_input = 4'hf;
        cyc(6);
        chk(16'(drive), 16'h0, "on before supply");
        supply_above_rise = 1'b1;
        cyc(3);
        chk(16'(drive), 16'hf0, "on after supply");
        $display("power-on test done");
    endtask

    task automatic t_enable();
        // toggles every few cycles, far above the slowest dimming rate allowed
        for (int i = 0; i < LFS_NCH; i++) begin
            channel_enable_input = 4'h1 << i;
            cyc(2);
            chk(16'(drive), 16'({channel_enable_input, 4'h0}), "single enable");
        end
        channel_enable_input = 4'hf;
        cyc(2);
        $display("enable test done");
    endtask

    task automatic t_short(input int ch, input logic on_shared);
        logic [3:0] m;
        m = 4'h1 << ch;
        if (on_shared) short_shared[ch] = 1'b1;
        else short_direct[ch] = 1'b1;
        wait_for(ch, 1'b1, SG, SG + 3, "short raise");
        chk(16'(fault_bus_oe), 16'h1, "pulldown on");
        chk(16'(fault_bus_out), 16'h0, "pulldown level");
        chk(16'(drive), 16'({~m, m}), "retry only");
        channel_enable_input[ch] = 1'b0;
        cyc(3);
        chk(16'(drive.retry_on), 16'(m), "retry ignores enable");
        short_direct = 4'h0;
        short_shared = 4'h0;
        wait_for(ch, 1'b0, RD + RY, RD + RY + 5, "recovery");
        chk(16'(fault_bus_oe), 16'h0, "pulldown off");
        chk(16'(drive), 16'({~m, 4'h0}), "back to enable");
        channel_enable_input = 4'hf;
        cyc(2);
        $display("short test done");
    endtask

    task automatic t_restart();
        repeat (2) begin
            short_direct[1] = 1'b1;
            cyc(SG - 2);
            short_direct[1] = 1'b0;
            cyc(2);
        end
        chk(16'(short_fault), 16'h0, "deglitch restart");
        channel_enable_input[3] = 1'b0;
        short_direct[3] = 1'b1;
        cyc(SG + 6);
        chk(16'(short_fault), 16'h0, "disabled channel");
        short_direct[3] = 1'b0;
        channel_enable_input[3] = 1'b1;
        cyc(2);
        $display("restart test done");
    endtask

    task automatic t_ext();
        foreign_pull = 1'b1;
        cyc(BD - 1);
        chk(16'(drive.reg_on), 16'hf, "bus glitch");
        cyc(4);
        chk(16'({drive, low_current_mode, fault_bus_oe}), 16'h2, "bus low mode");
        foreign_pull = 1'b0;
        cyc(BD + 4);
        chk(16'({drive, low_current_mode}), 16'h1e0, "bus released");
        $display("fault bus test done");
    endtask

    task automatic t_brownout();
        short_direct[0] = 1'b1;
        cyc(SG + 4);
        supply_below_fall = 1'b1;
        cyc(3);
        chk(16'({drive, short_fault, fault_bus_oe}), 16'h0, "supply low");
        short_direct[0] = 1'b0;
        supply_below_fall = 1'b0;
        cyc(4);
        chk(16'(drive), 16'hf0, "supply back");
        $display("brownout test done");
    endtask

    initial begin
        cyc(16);
        arst_n = 1'b1;
        t_por();
        t_enable();
        t_short(0, 1'b0);
        t_short(2, 1'b1);
        t_restart();
        t_ext();
        t_brownout();
        close_out();
    end
endmodule
